//--- mpdi_pkg.sv
// Purpose: Shared constants and carriers for the MII data path block
// Assumes: System clock of 40 MHz
// Notes:   All timing counts derive from the named rates below
package mpdi_pkg;
   // -------------------------------------------------------------
   // Rates
   // -------------------------------------------------------------
   localparam int SYS_CLK_KHZ    = 40000;   // System clock rate
   localparam int MII_FAST_KHZ   = 25000;   // Link clock at 100 Mbps
   localparam int MII_SLOW_KHZ   = 2500;    // Link clock at 10 Mbps
   // Half periods in system cycles, at least one
   localparam int HALF_FAST_RAW  = SYS_CLK_KHZ / (2 * MII_FAST_KHZ);
   localparam int HALF_FAST_CYC  = (HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW;
   localparam int HALF_SLOW_CYC  = SYS_CLK_KHZ / (2 * MII_SLOW_KHZ);
   localparam int DIV_W          = 8;       // Divider counter width
   localparam int NIB_W          = 4;       // Nibble width
   localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed
   {
      logic [NIB_W-1:0] data;  // Nibble, bit 0 is least significant
      logic             valid; // Valid data
      logic             error; // Error flag
   } mpdi_nib_t;
endpackage

//--- mpdi_clk_div.sv
// Purpose: Divider making one link clock and its edge enables
// Assumes: Half period counts of at least one
// Notes:   The clock output comes straight from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module mpdi_clk_div
#(
   parameter int HALF_FAST = mpdi_pkg::HALF_FAST_CYC,
   parameter int HALF_SLOW = mpdi_pkg::HALF_SLOW_CYC
)
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic speedFast,   // High selects 100 Mbps
   output logic      mclk,        // Divided link clock
   output logic      riseEn,      // Pulse: mclk goes high next cycle
   output logic      fallEn       // Pulse: mclk goes low next cycle
);
   localparam logic [mpdi_pkg::DIV_W-1:0] LIM_FAST = mpdi_pkg::DIV_W'(HALF_FAST - 1);
   localparam logic [mpdi_pkg::DIV_W-1:0] LIM_SLOW = mpdi_pkg::DIV_W'(HALF_SLOW - 1);
   logic [mpdi_pkg::DIV_W-1:0] cnt_reg;   // Half period counter
   logic [mpdi_pkg::DIV_W-1:0] limit;     // Current terminal count
   logic                       wrap;      // Half period over
   logic                       speedFast_reg; // Speed latched at a wrap

   // Latched speed picks the terminal count, so a speed change never
   // cuts a half period short and the link clock stays glitch free
   assign limit  = speedFast_reg ? LIM_FAST : LIM_SLOW;
   assign wrap   = (cnt_reg >= limit);
   assign riseEn = wrap && !mclk;
   assign fallEn = wrap && mclk;

   // -------------------------------------------------------------
   // Counter and clock toggle
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         mclk    <= 1'b0;
      end
      else if (wrap)
      begin
         cnt_reg <= '0;
         mclk    <= ~mclk;
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Speed latch, updated only where a half period ends
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         speedFast_reg <= 1'b0;
      end
      else if (wrap)
      begin
         speedFast_reg <= speedFast;
      end
   end
endmodule
`default_nettype wire

//--- mpdi_mii_phy.sv
// Purpose: PHY side MII data path: clocks, receive nibbles, CRS, COL
// Assumes: Line side delivers received nibbles and status on clk_sys
// Notes:   Both MII clocks come from clk_sys dividers, so at 40 MHz
//          the fast rate is only approximate; the slow rate is exact
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Generate TX clock at 2.5 or 20 MHz (25 MHz nominal)
// - Generate RX clock at 2.5 or 20 MHz (25 MHz nominal)
// - RX nibble changes on RX clock, LSB first
// - Data valid marks every valid RX nibble
// - Receive error flagged on RX clock
// - Collision held high while it lasts
// - Collision asynchronous, off in full duplex
// - Half duplex: carrier on transmit or receive
// - Full duplex: carrier only on receive
// - Carrier rises anytime, falls on RX clock
module mpdi_mii_phy
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   linkFast,     // Resolved speed, high 100 Mbps
   input  wire logic                   fullDuplex,   // Duplex control bit
   input  wire logic                   lineRxActive, // Line carrier present
   input  wire logic                   lineRxValid,  // Line nibble valid
   input  wire logic                   lineRxErr,    // Line decode error
   input  wire logic [mpdi_pkg::NIB_W-1:0] lineRxData, // Line nibble
   input  wire logic                   txEn,         // MAC transmit enable pin
   input  wire logic [mpdi_pkg::NIB_W-1:0] txData,   // MAC transmit nibble pins
   output logic                        txClk,        // MII transmit clock
   output logic                        rxClk,        // MII receive clock
   output logic [mpdi_pkg::NIB_W-1:0]  rxData,       // MII receive nibble
   output logic                        rxDv,         // Receive data valid
   output logic                        rxEr,         // Receive error
   output logic                        crs,          // Carrier sense
   output logic                        col,          // Collision
   output logic                        txOutValid,   // Captured transmit valid
   output logic [mpdi_pkg::NIB_W-1:0]  txOutData     // Captured transmit nibble
);
   // -------------------------------------------------------------
   // Clock generation
   // -------------------------------------------------------------
   logic txRise;   // TX clock about to rise
   logic rxFall;   // RX clock about to fall
   // The other two edge enables are not needed and stay open

   // Both dividers follow the resolved link speed
   mpdi_clk_div u_txdiv
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .speedFast (linkFast),
      .mclk      (txClk),
      .riseEn    (txRise),
      .fallEn    ()
   );
   mpdi_clk_div u_rxdiv
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .speedFast (linkFast),
      .mclk      (rxClk),
      .riseEn    (),
      .fallEn    (rxFall)
   );

   // -------------------------------------------------------------
   // Transmit capture
   // -------------------------------------------------------------
   logic                      txEnS1_reg;   // Sync stage one
   logic                      txEnS2_reg;   // Sync stage two
   logic [mpdi_pkg::NIB_W-1:0] txDS1_reg;   // Sync stage one
   logic [mpdi_pkg::NIB_W-1:0] txDS2_reg;   // Sync stage two

   // Pins cross into clk_sys through two flops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txEnS1_reg <= 1'b0;
         txEnS2_reg <= 1'b0;
         txDS1_reg  <= mpdi_pkg::NIB_ZERO;
         txDS2_reg  <= mpdi_pkg::NIB_ZERO;
      end
      else
      begin
         txEnS1_reg <= txEn;
         txEnS2_reg <= txEnS1_reg;
         txDS1_reg  <= txData;
         txDS2_reg  <= txDS1_reg;
      end
   end

   // Sample at our own rising edge; MAC changed data at the
   // previous rise, so it has had a full period to settle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txOutValid <= 1'b0;
         txOutData  <= mpdi_pkg::NIB_ZERO;
      end
      else if (txRise)
      begin
         txOutValid <= txEnS2_reg;
         txOutData  <= txEnS2_reg ? txDS2_reg : mpdi_pkg::NIB_ZERO;
      end
   end

   // -------------------------------------------------------------
   // Receive nibble path
   // -------------------------------------------------------------
   mpdi_pkg::mpdi_nib_t rxNib_next;   // Nibble to present next

   // Invalid nibbles are blanked so RXD only carries data with DV
   always_comb
   begin
      rxNib_next.data  = lineRxValid ? lineRxData : mpdi_pkg::NIB_ZERO;
      rxNib_next.valid = lineRxValid;
      rxNib_next.error = lineRxErr;
   end

   // Outputs change on RX clock falling edge, stable at its rise
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxData <= mpdi_pkg::NIB_ZERO;
         rxDv   <= 1'b0;
         rxEr   <= 1'b0;
      end
      else if (rxFall)
      begin
         rxData <= rxNib_next.data;
         rxDv   <= rxNib_next.valid;
         rxEr   <= rxNib_next.error;
      end
   end

   // -------------------------------------------------------------
   // Carrier sense and collision
   // -------------------------------------------------------------
   logic txBusy;    // Transmit in progress
   logic carrier;   // Carrier wanted now

   assign txBusy  = txEnS2_reg;
   assign carrier = lineRxActive || (!fullDuplex && txBusy);

   // Rise at once, fall only at an RX clock edge
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         crs <= 1'b0;
      end
      else if (carrier)
      begin
         crs <= 1'b1;
      end
      else if (rxFall)
      begin
         crs <= 1'b0;
      end
   end

   // Collision needs no link clock; held while both sides are busy in half duplex
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         col <= 1'b0;
      end
      else
      begin
         col <= !fullDuplex && txBusy && lineRxActive;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   sequence rxEdge_s;
      rxFall;
   endsequence

   rx_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !$past(rxFall) |-> $stable(rxData))
      else $error("RX nibble changed off its clock edge");
   dv_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rxEdge_s ##1 1'b1 |-> rxDv == $past(lineRxValid))
      else $error("Data valid does not follow line valid");
   er_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rxEdge_s ##1 1'b1 |-> rxEr == $past(lineRxErr))
      else $error("Receive error does not follow line error");
   col_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fullDuplex && $past(fullDuplex) |-> !col)
      else $error("Collision active in full duplex");
   col_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!fullDuplex && txBusy && lineRxActive) [*2] |-> col)
      else $error("Collision dropped while it persists");
   crs_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !fullDuplex && txBusy |=> crs)
      else $error("Carrier missing during half duplex transmit");
   crs_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(crs) |-> $past(rxFall))
      else $error("Carrier removed off the RX clock edge");
   crs_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fullDuplex && !lineRxActive && rxFall |=> !crs)
      else $error("Carrier held for transmit in full duplex");
   tx_clk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      linkFast && $past(linkFast) && txRise |=> txClk ##1 !txClk)
      else $error("TX clock high phase not one cycle at 100 Mbps");
   crs_rx_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      lineRxActive |=> crs)
      else $error("Carrier missing while receiving");
   rx_slow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !linkFast && $past(!linkFast) && $rose(rxClk) |=> rxClk [*7])
      else $error("RX clock high phase too short at 10 Mbps");
endmodule
`default_nettype wire

//--- mpdi_mac_model.sv
// Purpose: MAC side transmit driver for the MII data path bench
// Assumes: txClk comes from the block under test
// Notes:   Idle TXD toggles so a stale nibble never looks valid
`timescale 1ns/1ps
`default_nettype none
module mpdi_mac_model
#(
   parameter int FRAME_LEN = 6   // Nibbles per frame
)
(
   input  wire logic                       txClk,
   input  wire logic                       rst_n,
   input  wire logic                       go,     // Level: send one frame
   output var  logic                       txEn,
   output var  logic [mpdi_pkg::NIB_W-1:0] txData
);
   int cnt;   // Nibbles sent so far

   // Launch just after each TX clock rise, as a real MAC does; idle
   // levels are set at time zero so the pins are never unknown
   initial
   begin
      txEn   = 1'b0;
      txData = 4'hA;
      cnt    = 0;
      forever
      begin
         @(posedge txClk or negedge rst_n);
         if (!rst_n)
         begin
            txEn   = 1'b0;
            txData = 4'hA;
            cnt    = 0;
         end
         else
         begin
            #3;
            if (go && cnt < FRAME_LEN)
            begin
               txEn   = 1'b1;
               txData = 4'(cnt) ^ 4'h5;
               cnt++;
            end
            else
            begin
               // Re-arm only once go drops, so one frame per request
               if (!go)
                  cnt = 0;
               txEn   = 1'b0;
               txData = ~txData;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- mii_phy_data_interface_tb_top.sv
// Purpose: Self-checking bench for the PHY side MII data path
// Assumes: 40 MHz system clock, link clocks made by the block
// Notes:   Fast link clock is checked at the 20 MHz the block can make
`timescale 1ns/1ps
`default_nettype none
module mii_phy_data_interface_tb_top;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       linkFast = 1'b0;
   logic       fullDuplex = 1'b0;
   logic       lineRxActive = 1'b0;
   logic       lineRxValid = 1'b0;
   logic       lineRxErr = 1'b0;
   logic [3:0] lineRxData = 4'h0;
   logic       go = 1'b0;   // Frame request to the MAC model
   logic       txEn, txClk, rxClk, rxDv, rxEr, crs, col, txOutValid;
   logic [3:0] txData, rxData, txOutData;
   int         mismatches = 0;
   int         cmp_count = 0;
   int         cycles = 0;   // Hang guard

   mpdi_mii_phy mpdi_mii_phy_inst (.clk_sys, .rst_n, .linkFast, .fullDuplex, .lineRxActive,
      .lineRxValid, .lineRxErr, .lineRxData, .txEn, .txData, .txClk, .rxClk, .rxData,
      .rxDv, .rxEr, .crs, .col, .txOutValid, .txOutData);
   mpdi_mac_model #(.FRAME_LEN(6)) mpdi_mac_model_inst (.txClk, .rst_n, .go, .txEn, .txData);

   always #12.5 clk_sys = ~clk_sys;

   // Whole run needs well under 1000 cycles; far above that means a hang
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         mismatches++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic end_sim();
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("unexpected %0t %s", $time, msg);
      end
   endtask

   // Leaves us just after an edge, where inputs may change
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_clocks(input logic fast, input int per);
      time t0;
      cyc(1);
      linkFast = fast;
      // Speed change lands at a wrap, so let it settle
      repeat (3) @(posedge txClk);
      t0 = $time;
      @(negedge txClk);
      chk($time - t0 == per * 25 / 2, "tx high time");
      @(posedge txClk);
      chk($time - t0 == per * 25, "tx period");
      @(posedge rxClk);
      t0 = $time;
      @(posedge rxClk);
      chk($time - t0 == per * 25, "rx period");
   endtask

   // Line value held a whole RX period, read after the next fall
   task automatic rx_nib(input logic v, input logic e, input logic [3:0] d);
      @(negedge rxClk);
      #2;
      lineRxActive = v;
      lineRxValid = v;
      lineRxErr = e;
      lineRxData = d;
      @(negedge rxClk);
      #1;
      chk(rxDv === v && rxEr === e, "rx flags");
      chk(rxData === (v ? d : 4'h0), "rx nibble");
      chk(crs === v, "crs follows receive");
   endtask

   task automatic t_tx();
      @(posedge txClk);
      #2;
      go = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         @(posedge txClk);
         #1;
         chk(txOutValid === 1'b1 && txOutData === (4'(i) ^ 4'h5), "tx nibble");
      end
      @(posedge txClk);
      #1;
      chk(txOutValid === 1'b0 && txOutData === 4'h0, "tx idle");
      go = 1'b0;
      // Model must see go low at a TX clock rise before the next request
      cyc(1);
   endtask

   task automatic t_crs();
      fullDuplex = 1'b0;
      go = 1'b1;
      for (int i = 0; i < 64 && txEn !== 1'b1; i++)
         cyc(1);
      cyc(4);
      chk(crs === 1'b1 && col === 1'b0, "crs on transmit");
      lineRxActive = 1'b1;
      cyc(2);
      chk(col === 1'b1, "collision raised");
      cyc(8);
      chk(col === 1'b1 && crs === 1'b1, "collision held");
      fullDuplex = 1'b1;
      cyc(2);
      chk(col === 1'b0 && crs === 1'b1, "full duplex receive");
      lineRxActive = 1'b0;
      cyc(20);
      chk(txEn === 1'b1 && crs === 1'b0, "no crs on transmit");
      lineRxActive = 1'b1;
      cyc(2);
      chk(crs === 1'b1, "crs rises mid period");
      // Drop carrier right after a fall: crs must wait a full period
      @(negedge rxClk);
      #2;
      lineRxActive = 1'b0;
      cyc(3);
      chk(crs === 1'b1, "crs held to rx fall");
      @(negedge rxClk);
      #1;
      chk(crs === 1'b0, "crs drops on rx fall");
      cyc(1);
      go = 1'b0;
      cyc(100);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk_sys);
      #2;
      chk(txClk === 1'b0 && crs === 1'b0 && rxDv === 1'b0, "reset outputs");
      rst_n = 1'b1;
      cyc(2);
      t_clocks(1'b0, 16);
      t_clocks(1'b1, 2);
      cyc(1);
      linkFast = 1'b0;
      cyc(40);
      rx_nib(1'b1, 1'b0, 4'h1);
      rx_nib(1'b1, 1'b0, 4'h8);
      rx_nib(1'b1, 1'b1, 4'h6);
      rx_nib(1'b0, 1'b0, 4'hF);
      t_tx();
      t_crs();
      end_sim();
   end
endmodule
`default_nettype wire
